// [rtl/uart_frame_consts.vh]
// Purpose: constants for the serial port register frame
// Assumes: byte addresses on a 32-bit little-endian bus
// Notes: control register offset is a local choice
`ifndef UART_FRAME_CONSTS_VH
`define UART_FRAME_CONSTS_VH
`define OFF_CHAR_DATA 12'h000
`define OFF_RX_ERR 12'h004
`define OFF_PORT_FLAGS 12'h018
`define OFF_IRQ_MASK 12'h038
`define OFF_IRQ_RAW 12'h03C
`define OFF_IRQ_MASKED 12'h040
`define OFF_IRQ_CLEAR 12'h044
`define OFF_CONTROL 12'h080
`define FIFO_DEPTH_DEF 32
`define BAUD_DIV_DEF 16'h01B2
`define IRQ_LO 4
`define IRQ_HI 10
`define IRQ_RX 4
`define IRQ_TX 5
`define IRQ_RT 6
`define IRQ_FE 7
`define IRQ_PE 8
`define IRQ_BE 9
`define IRQ_OE 10
`define IRQ_FIELD 32'h0000_07F0
`define MASK_WO1 32'h0000_000F
`define CTL_PORT_EN 0
`define CTL_TX_EN 8
`define CTL_RX_EN 9
`define CTL_FIFO_EN 4
`define CTL_WLEN_LO 5
`define CTL_RESET 32'h0000_0060
`define WLEN_EIGHT 2'h3
`define RT_CHARS 32
`endif

// [rtl/char_fifo.v]
// Purpose: synchronous FIFO for one direction of characters
// Assumes: push ignored when full, pop ignored when empty
// Notes: depth must be a power of two
`timescale 1ns/1ps
module char_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk_sys,
   input wire rst_n,
   input wire clkEn,
   input wire flush,
   input wire push,
   input wire [WIDTH-1:0] pushData,
   input wire pop,
   output wire [WIDTH-1:0] popData,
   output wire full,
   output wire empty
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_q;
   reg [AW:0] rdPtr_q;
   wire doPush = push && !full;
   wire doPop = pop && !empty;
   assign popData = mem[rdPtr_q[AW-1:0]];
   assign empty = (wrPtr_q == rdPtr_q);
   assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   always @(posedge clk_sys) begin
      if (clkEn && doPush) begin
         mem[wrPtr_q[AW-1:0]] <= pushData;
      end
   end
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
      end else if (clkEn) begin
         if (flush) begin
            wrPtr_q <= {(AW+1){1'b0}};
            rdPtr_q <= {(AW+1){1'b0}};
         end else begin
            if (doPush) begin
               wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doPop) begin
               rdPtr_q <= rdPtr_q + 1'b1;
            end
         end
      end
   end
endmodule // char_fifo

// [rtl/generic_uart_frame.v]
// Purpose: minimal serial port with register frame over Avalon-MM
// Assumes: 8N1 line, baud from a divider parameter, 16x oversampled receive
// Notes: one wait state on every access; waitrequest high while idle
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "uart_frame_consts.vh"
module generic_uart_frame #(
   parameter FIFO_DEPTH = `FIFO_DEPTH_DEF,
   parameter FIFO_AW = 5,
   parameter [15:0] BAUD_DIV = `BAUD_DIV_DEF
) (
   input wire clk_sys,
   input wire rst_n,
   input wire clkEn,
   input wire [11:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   output reg combinedIrqOut,
   // serial data only: no DMA, modem, flow control or infrared pins
   input wire serialIn,
   output reg serialOut
);
   localparam [2:0] TX_IDLE = 3'b001;
   localparam [2:0] TX_SHIFT = 3'b010;
   localparam [2:0] TX_STOP = 3'b100;
   localparam [2:0] RX_IDLE = 3'b001;
   localparam [2:0] RX_SHIFT = 3'b010;
   localparam [2:0] RX_STOP = 3'b100;

   reg [31:0] ctl_q;
   reg [10:4] mask_q;
   reg [10:4] raw_q;
   reg [3:0] rxErr_q;
   reg ack_q;
   reg [2:0] txState_q;
   reg [15:0] txDiv_q;
   reg [3:0] txTick_q;
   reg [3:0] txBit_q;
   reg [7:0] txShift_q;
   reg txBusy_q;
   reg [2:0] rxState_q;
   reg [15:0] rxDiv_q;
   reg [3:0] rxTick_q;
   reg [3:0] rxBit_q;
   reg [7:0] rxShift_q;
   reg rxBrk_q;
   reg [5:0] rtCnt_q;

   wire portEn = ctl_q[`CTL_PORT_EN];
   wire txEn = portEn && ctl_q[`CTL_TX_EN];
   wire rxEn = portEn && ctl_q[`CTL_RX_EN];
   wire fifoEn = ctl_q[`CTL_FIFO_EN];
   // aligned word decode, sub-word accesses share the base
   wire [11:0] regAddr = {address[11:2], 2'b00};
   wire acc = (read || write) && !ack_q;
   wire wrAcc = write && acc;
   wire rdAcc = read && acc;
   // byte lane mask, lane 0 is bits 7:0
   wire [31:0] beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
      {8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [31:0] wrBits = writedata & beMask;

   wire txFull, txEmpty, rxFull, rxEmpty;
   wire [7:0] txHead;
   wire [11:0] rxHead;
   // data register write pushes, read pops
   wire txPush = wrAcc && regAddr == `OFF_CHAR_DATA && byteenable[0];
   wire rxPop = rdAcc && regAddr == `OFF_CHAR_DATA;
   wire txPop;
   wire rxPush;
   wire [11:0] rxWord;
   // without FIFO enable the queues act as one-entry holding registers
   wire txFullEff = fifoEn ? txFull : !txEmpty;
   wire rxFullEff = fifoEn ? rxFull : !rxEmpty;

   char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) txFifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .flush(!portEn),
      .push(txPush && !txFullEff),
      .pushData(wrBits[7:0]),
      .pop(txPop),
      .popData(txHead),
      .full(txFull),
      .empty(txEmpty)
   );
   char_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rxFifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .flush(!portEn),
      .push(rxPush && !rxFullEff),
      .pushData(rxWord),
      .pop(rxPop),
      .popData(rxHead),
      .full(rxFull),
      .empty(rxEmpty)
   );

   // transmitter, 8N1
   wire txTickEnd = (txDiv_q == 16'h0000);
   assign txPop = (txState_q == TX_IDLE) && txEn && !txEmpty;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txState_q <= TX_IDLE;
         txDiv_q <= 16'h0000;
         txTick_q <= 4'h0;
         txBit_q <= 4'h0;
         txShift_q <= 8'h00;
         txBusy_q <= 1'b0;
         serialOut <= 1'b1;
      end else if (clkEn) begin
         txDiv_q <= txTickEnd ? BAUD_DIV : txDiv_q - 16'h0001;
         case (txState_q)
            TX_IDLE: begin
               serialOut <= 1'b1;
               txBusy_q <= 1'b0;
               if (txPop) begin
                  // eight data bits after start bit
                  txShift_q <= txHead;
                  txBit_q <= 4'h0;
                  txTick_q <= 4'h0;
                  serialOut <= 1'b0;
                  txBusy_q <= 1'b1;
                  txState_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (txTickEnd) begin
                  txTick_q <= txTick_q + 4'h1;
                  if (txTick_q == 4'hF) begin
                     serialOut <= txShift_q[0];
                     txShift_q <= {1'b0, txShift_q[7:1]};
                     txBit_q <= txBit_q + 4'h1;
                     if (txBit_q == 4'h8) begin
                        serialOut <= 1'b1;
                        txState_q <= TX_STOP;
                     end
                  end
               end
            end
            TX_STOP: begin
               if (txTickEnd) begin
                  txTick_q <= txTick_q + 4'h1;
                  if (txTick_q == 4'hF) begin
                     txState_q <= TX_IDLE;
                  end
               end
            end
            default: txState_q <= TX_IDLE;
         endcase
      end
   end

   // receiver, 16x oversampling, mid-bit sampling
   wire rxTickEnd = (rxDiv_q == 16'h0000);
   // frame ends at mid stop bit, where the stop level is judged
   wire rxDone = (rxState_q == RX_STOP) && rxTickEnd && rxTick_q == 4'h7;
   // stop bit seen low is a framing fault
   wire rxFrameErr = !serialIn;
   wire rxBreak = rxFrameErr && rxShift_q == 8'h00 && rxBrk_q;
   wire rxOverrun = rxDone && rxFullEff;
   // error bits 11:8 stored with each character
   assign rxWord = {rxOverrun, rxBreak, 1'b0, rxFrameErr, rxShift_q};
   assign rxPush = rxDone;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxState_q <= RX_IDLE;
         rxDiv_q <= 16'h0000;
         rxTick_q <= 4'h0;
         rxBit_q <= 4'h0;
         rxShift_q <= 8'h00;
         rxBrk_q <= 1'b0;
      end else if (clkEn) begin
         rxDiv_q <= rxTickEnd ? BAUD_DIV : rxDiv_q - 16'h0001;
         case (rxState_q)
            RX_IDLE: begin
               rxBit_q <= 4'h0;
               rxBrk_q <= 1'b1;
               // ticks keep running while idle so the timeout can count bit times
               if (rxEn && !serialIn && rxTickEnd) begin
                  rxTick_q <= 4'h0;
                  rxState_q <= RX_SHIFT;
               end else if (rxTickEnd) begin
                  rxTick_q <= rxTick_q + 4'h1;
               end
            end
            RX_SHIFT: begin
               if (rxTickEnd) begin
                  rxTick_q <= rxTick_q + 4'h1;
                  if (rxTick_q == 4'h7) begin
                     if (rxBit_q == 4'h0 && serialIn) begin
                        rxState_q <= RX_IDLE;
                     end else if (rxBit_q != 4'h0) begin
                        rxShift_q <= {serialIn, rxShift_q[7:1]};
                        rxBrk_q <= rxBrk_q && !serialIn;
                     end
                  end
                  if (rxTick_q == 4'hF) begin
                     rxBit_q <= rxBit_q + 4'h1;
                     if (rxBit_q == 4'h8) begin
                        rxState_q <= RX_STOP;
                     end
                  end
               end
            end
            RX_STOP: begin
               if (rxTickEnd) begin
                  rxTick_q <= rxTick_q + 4'h1;
                  // leave at mid stop bit so a back-to-back start edge is caught
                  if (rxTick_q == 4'h7) begin
                     rxState_q <= RX_IDLE;
                  end
               end
            end
            default: rxState_q <= RX_IDLE;
         endcase
      end
   end

   // receive timeout: idle line for 32 bit times with data waiting
   wire bitTimeEnd = rxTickEnd && rxTick_q == 4'hF;
   wire rtEvent = bitTimeEnd && rtCnt_q == `RT_CHARS - 1;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rtCnt_q <= 6'h00;
      end else if (clkEn) begin
         if (rxEmpty || rxState_q != RX_IDLE || rxPop) begin
            rtCnt_q <= 6'h00;
         end else if (bitTimeEnd && rtCnt_q != `RT_CHARS) begin
            // one step per idle bit time, saturating
            rtCnt_q <= rtCnt_q + 6'h01;
         end
      end
   end

   // interrupt events, sticky until cleared
   wire [10:4] evt;
   assign evt[`IRQ_RX] = rxDone;
   assign evt[`IRQ_TX] = txPop;
   assign evt[`IRQ_RT] = rtEvent;
   assign evt[`IRQ_FE] = rxDone && rxFrameErr;
   assign evt[`IRQ_PE] = 1'b0;
   assign evt[`IRQ_BE] = rxDone && rxBreak;
   assign evt[`IRQ_OE] = rxOverrun;

   wire wrMask = wrAcc && regAddr == `OFF_IRQ_MASK;
   wire wrClear = wrAcc && regAddr == `OFF_IRQ_CLEAR;
   wire wrRxErr = wrAcc && regAddr == `OFF_RX_ERR;
   wire wrCtl = wrAcc && regAddr == `OFF_CONTROL;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         raw_q <= 7'h00;
         mask_q <= 7'h00;
         rxErr_q <= 4'h0;
         ctl_q <= `CTL_RESET;
      end else if (clkEn) begin
         // write-one clear; a same-cycle event wins
         raw_q <= (raw_q & ~(wrClear ? wrBits[`IRQ_HI:`IRQ_LO] : 7'h00)) | evt;
         if (wrMask) begin
            mask_q <= (mask_q & ~beMask[`IRQ_HI:`IRQ_LO]) | wrBits[`IRQ_HI:`IRQ_LO];
         end
         // any write clears; a new error in the same cycle stays
         if (rxPop) begin
            rxErr_q <= rxHead[11:8];
         end else if (wrRxErr) begin
            rxErr_q <= 4'h0;
         end
         // software setup of enables; the word length field is stored but unused, the line stays 8 bits
         if (wrCtl) begin
            ctl_q <= (ctl_q & ~beMask) | wrBits;
         end
      end
   end

   // flag bits 7:3: TXFE RXFF TXFF RXFE BUSY
   wire [31:0] flags = {24'h00_0000, txEmpty, rxFullEff, txFullEff, rxEmpty,
      txBusy_q || !txEmpty, 3'b000};
   wire [10:4] masked = raw_q & mask_q;

   // reserved bits zero except in control, which reads back all written bits; unmapped addresses read zero
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h0000_0000;
      case (regAddr)
         `OFF_CHAR_DATA: rdMux = {20'h0_0000, rxHead};
         `OFF_RX_ERR: rdMux = {28'h000_0000, rxErr_q};
         `OFF_PORT_FLAGS: rdMux = flags;
         // mask read back, write-ones field shown as ones
         `OFF_IRQ_MASK: rdMux = {21'h00_0000, mask_q, 4'h0} | `MASK_WO1;
         // raw and masked status in 10:4
         `OFF_IRQ_RAW: rdMux = {21'h00_0000, raw_q, 4'h0};
         `OFF_IRQ_MASKED: rdMux = {21'h00_0000, masked, 4'h0};
         `OFF_CONTROL: rdMux = ctl_q;
         default: rdMux = 32'h0000_0000;
      endcase
      if (regAddr == `OFF_CHAR_DATA && rxEmpty) begin
         rdMux = 32'h0000_0000;
      end
   end

   // one-wait-state bus slave
   // effects land on the request edge; the answer follows one cycle later
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
         combinedIrqOut <= 1'b0;
      end else if (clkEn) begin
         ack_q <= acc;
         waitrequest <= !acc;
         if (rdAcc) begin
            readdata <= rdMux;
         end
         combinedIrqOut <= |((raw_q | evt) & mask_q);
      end
   end
endmodule // generic_uart_frame

// [dv/generic_uart_frame_chk.sv]
// Purpose: bus and interrupt checks for the serial port frame
// Assumes: one wait state per access, clkEn held high
// Notes: mask copy is tracked from completed writes
`timescale 1ns/1ps
module generic_uart_frame_chk (
   input wire clk_sys,
   input wire rst_n,
   input wire [11:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire combinedIrqOut
);
   reg [10:4] maskQ;
   wire done = !waitrequest;
   wire rdDone = read && done;
   wire [9:0] word = address[11:2];
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         maskQ <= 7'h00;
      end else if (write && done && word == 10'h00E) begin
         if (byteenable[0]) maskQ[7:4] <= writedata[7:4];
         if (byteenable[1]) maskQ[10:8] <= writedata[10:8];
      end
   end
   ans_bound_a: assert property ((read || write) |-> ##[0:2] done)
      else $error("access not answered");
   ans_pulse_a: assert property (done |=> waitrequest)
      else $error("waitrequest low too long");
   rdata_hold_a: assert property (!$stable(readdata) |-> rdDone)
      else $error("readdata moved outside a read");
   mask_read_a: assert property (rdDone && word == 10'h00E |->
      readdata == {21'h00_0000, maskQ, 4'hF}) else $error("mask readback wrong");
   data_rsvd_a: assert property (rdDone && word == 10'h000 |->
      readdata[31:12] == 20'h0_0000) else $error("data upper bits set");
   err_rsvd_a: assert property (rdDone && word == 10'h001 |->
      readdata[31:4] == 28'h000_0000) else $error("error status upper bits set");
   flag_rsvd_a: assert property (rdDone && word == 10'h006 |->
      readdata[31:8] == 24'h00_0000 && readdata[2:0] == 3'h0) else $error("flag reserved set");
   stat_rsvd_a: assert property (rdDone && (word == 10'h00F || word == 10'h010) |->
      readdata[3:0] == 4'h0 && readdata[31:11] == 21'h00_0000) else $error("status reserved set");
   empty_read_a: assert property (rdDone && (word == 10'h011 || word == 10'h040) |->
      readdata == 32'h0000_0000) else $error("unmapped read not zero");
   irq_masked_a: assert property ((maskQ == 7'h00) [*3] |-> !combinedIrqOut)
      else $error("interrupt with all masked");
   cover property (rdDone && word == 10'h000);
   cover property (combinedIrqOut);
   cover property (write && done && word == 10'h011);
endmodule // generic_uart_frame_chk
bind generic_uart_frame generic_uart_frame_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .combinedIrqOut(combinedIrqOut));

// [dv/uart_line_model.sv]
// Purpose: serial line partner, 8N1 in both directions
// Assumes: bit time of BIT_CLKS system clocks
// Notes: stop bit can be forced low for a framing fault
`timescale 1ns/1ps
module uart_line_model #(
   parameter BIT_CLKS = 32
) (
   input wire clk_sys,
   input wire lineIn,
   output reg lineOut
);
   reg [7:0] rxByte;
   integer rxCount;
   integer i;
   initial begin
      lineOut = 1'b1;
      rxByte = 8'h00;
      rxCount = 0;
   end
   // one character, lsb first
   task send_char(input [7:0] ch, input stopOk);
      reg [9:0] frame;
      integer b;
      begin
         frame = {stopOk, ch, 1'b0};
         for (b = 0; b < 10; b = b + 1) begin
            lineOut <= frame[b];
            repeat (BIT_CLKS) @(posedge clk_sys);
         end
         // release for one clock so back-to-back frames never overlap
         lineOut <= 1'b1;
         @(posedge clk_sys);
      end
   endtask
   // sample mid-bit after the start edge
   always @(negedge lineIn) begin
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (i = 0; i < 8; i = i + 1) begin
         repeat (BIT_CLKS) @(posedge clk_sys);
         rxByte[i] = lineIn;
      end
      repeat (BIT_CLKS) @(posedge clk_sys);
      rxCount = rxCount + 1;
   end
endmodule // uart_line_model

// [dv/tb_generic_uart_frame.sv]
// Purpose: register-level test of the serial port frame
// Assumes: divider 1, so one bit is 32 clocks
// Notes: clkEn held high
`timescale 1ns/1ps
module tb_generic_uart_frame;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [11:0] address = 12'h000;
   reg read = 1'b0;
   reg write = 1'b0;
   reg [31:0] writedata = 32'h0000_0000;
   reg [3:0] byteenable = 4'hF;
   wire [31:0] readdata;
   wire waitrequest;
   wire combinedIrqOut;
   wire serialIn;
   wire serialOut;
   reg [31:0] rd;
   integer num_errors = 0;
   integer comparisons = 0;
   integer n;
   always #10 clk_sys = ~clk_sys;
   generic_uart_frame #(.FIFO_DEPTH(32), .FIFO_AW(5), .BAUD_DIV(16'h0001)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .combinedIrqOut(combinedIrqOut), .serialIn(serialIn),
      .serialOut(serialOut));
   uart_line_model #(.BIT_CLKS(32)) lineModel_u (.clk_sys(clk_sys), .lineIn(serialOut),
      .lineOut(serialIn));
   task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t %0s seen %h expected %h", $time, what, seen, exp);
         end
      end
   endtask
   task bus(input wr, input [11:0] a, input [31:0] d, input [3:0] be);
      integer t;
      begin
         read <= !wr;
         write <= wr;
         address <= a;
         writedata <= d;
         byteenable <= be;
         t = 0;
         @(posedge clk_sys);
         while (waitrequest !== 1'b0 && t < 100) begin
            @(posedge clk_sys);
            t = t + 1;
         end
         rd = readdata;
         read <= 1'b0;
         write <= 1'b0;
         check({31'h0, t < 100}, 32'h0000_0001, "answer");
         @(posedge clk_sys);
      end
   endtask
   task rdChk(input [11:0] a, input [31:0] exp, input [8*10:1] what);
      begin
         bus(1'b0, a, 32'h0000_0000, 4'hF);
         check(rd, exp, what);
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, num_errors);
         if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      #(40000 * 20);
      num_errors = num_errors + 1;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict;
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      check({29'h0, waitrequest, combinedIrqOut, serialOut}, 32'h0000_0005, "reset");
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rdChk(12'h038, 32'h0000_000F, "mask rst");
      bus(1'b1, 12'h080, 32'h0000_0371, 4'hF);
      bus(1'b1, 12'h038, 32'h0000_07FF, 4'h3);
      bus(1'b1, 12'h038, 32'h0000_000F, 4'h1);
      rdChk(12'h038, 32'h0000_070F, "mask lane");
      rdChk(12'h100, 32'h0000_0000, "unmapped");
      rdChk(12'h044, 32'h0000_0000, "clr read");
      $display("register test done");
      bus(1'b1, 12'h038, 32'h0000_07FF, 4'h3);
      bus(1'b1, 12'h000, 32'h0000_01A5, 4'h1);
      repeat (400) @(posedge clk_sys);
      check({24'h00_0000, lineModel_u.rxByte}, 32'h0000_00A5, "tx char");
      rdChk(12'h03C, 32'h0000_0020, "tx raw");
      check({31'h0, combinedIrqOut}, 32'h0000_0001, "tx irq");
      bus(1'b1, 12'h044, 32'h0000_0020, 4'h3);
      rdChk(12'h03C, 32'h0000_0000, "tx clear");
      $display("transmit test done");
      lineModel_u.send_char(8'h3C, 1'b1);
      repeat (1200) @(posedge clk_sys);
      rdChk(12'h03C, 32'h0000_0050, "rx raw");
      rdChk(12'h040, 32'h0000_0050, "rx masked");
      rdChk(12'h000, 32'h0000_003C, "rx data");
      rdChk(12'h000, 32'h0000_0000, "rx empty");
      bus(1'b1, 12'h044, 32'h0000_07F0, 4'h3);
      $display("receive test done");
      bus(1'b1, 12'h038, 32'h0000_000F, 4'h3);
      lineModel_u.send_char(8'h5A, 1'b0);
      repeat (64) @(posedge clk_sys);
      rdChk(12'h03C, 32'h0000_0090, "fe raw");
      rdChk(12'h040, 32'h0000_0000, "fe masked");
      check({31'h0, combinedIrqOut}, 32'h0000_0000, "fe irq");
      bus(1'b0, 12'h000, 32'h0000_0000, 4'hF);
      check({rd[31:12], 4'h0, rd[7:0]}, 32'h0000_005A, "fe data");
      check({31'h0, rd[11:8] != 4'h0}, 32'h0000_0001, "fe bits");
      rdChk(12'h004, {28'h000_0000, rd[11:8]}, "err stat");
      check({31'h0, rd[3:0] != 4'h0}, 32'h0000_0001, "err bits");
      bus(1'b1, 12'h004, 32'h0000_0000, 4'h1);
      rdChk(12'h004, 32'h0000_0000, "err clear");
      bus(1'b1, 12'h044, 32'h0000_07F0, 4'h3);
      $display("error test done");
      bus(1'b1, 12'h038, 32'h0000_040F, 4'h3);
      for (n = 0; n < 33; n = n + 1) begin
         lineModel_u.send_char(n[7:0], 1'b1);
      end
      repeat (40) @(posedge clk_sys);
      check({31'h0, combinedIrqOut}, 32'h0000_0001, "overrun");
      rdChk(12'h018, 32'h0000_00C0, "flags full");
      for (n = 0; n < 32; n = n + 1) begin
         rdChk(12'h000, n, "fifo");
      end
      rdChk(12'h000, 32'h0000_0000, "fifo end");
      rdChk(12'h018, 32'h0000_0090, "flags");
      $display("fifo test done");
      print_verdict;
   end
endmodule // tb_generic_uart_frame
